// ---- verilog/float_coprocessor_host_port.sv ----
// Host port of the floating-point coprocessor: interface registers and command sequencer.
// ==========================================================
// Functional notes
// - Host writes the instruction to command register, then reads the response.
// - The response encodes every further action the host must take.
// - A command arriving before operands are handed off gets a wait response.
// - Coprocessor identifier on upper address lines plus space code selects one.
// - The device answers only cycles in which it is selected.
// - The bus works at 8, 16 or 32 bit width.
// - The device never masters the bus; the host moves all data.
// - Exceptions needing a trap are signalled through the response.
// - The device runs on the bus clock sys_clk behind a handshake bus.
// - Eight general data registers of 80 bits each.
// - Control register holds trap enables, rounding mode and precision.
// - Status register holds condition codes, quotient and exception status.
// - Instruction address register holds the last executed instruction address.
// - Save reads a format word and stops the device; only a null restore acts, clearing control and status.
// - Up to eight coprocessors, each told apart by its identifier.
// - An access starts when selected and strobed.
// - Only response and save reads take the extra synchronous cycle.
`timescale 1ns/10ps
module float_coprocessor_host_port
  import fpcp_pkg::*;
#(
  parameter logic [2:0] CP_ID  = 3'h1,
  parameter int         NREG   = 8,
  parameter int         FW     = 80,
  parameter int         CYCLES = EXEC_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [2:0]  fc_i,
  output      logic [31:0] wb_dat_o,
  output      logic        wb_ack_o
);
  localparam int RW = $clog2(NREG);

  logic            ack_q;
  logic            sync_q;
  logic [31:0]     dat_q;
  seq_state_t      state_q;
  seq_state_t      state_d;
  logic [7:0]      cmd_q;
  logic [1:0]      left_q;
  logic [FW-1:0]   opnd_acc_q;
  logic            wait_q;
  logic            trap_q;
  logic            null_q;
  logic [31:0]     ctrl_q;
  logic [31:0]     stat_q;
  logic [31:0]     iaddr_stage_q;
  logic [31:0]     iaddr_q;
  logic [RW-1:0]   ex_dst_q;
  logic            ex_busy;
  logic            ex_done;
  logic            ex_wr;
  logic [FW-1:0]   ex_res;
  logic [3:0]      ex_cc;
  logic [7:0]      ex_exc;
  logic [FW-1:0]   reg_rd;

  // Lane merge lets 8, 16 and 32 bit hosts update any part of a word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int b = 0; b < 4; b++) old[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
    return old;
  endfunction : merge

  // ==========================================================
  // Bus decode
  // Selection needs the processor space code and our identifier; other cycles get no ack.
  wire       hit     = wb_cyc_i & wb_stb_i & (fc_i == FC_CPU_SPACE)
                       & (wb_adr_i[ID_MSB:ID_LSB] == CP_ID);
  wire       start   = hit & ~ack_q;
  wire [2:0] idx     = wb_adr_i[IDX_MSB:IDX_LSB];
  wire       mapped  = (wb_adr_i[MAP_MSB:MAP_LSB] == '0);
  wire       sync_rd = ~wb_we_i & mapped & ((idx == IDX_RESP) | (idx == IDX_SAVE));
  wire       acc     = start & (~sync_rd | sync_q);
  wire       wr      = acc & wb_we_i & mapped;
  wire       rd      = acc & ~wb_we_i & mapped;
  wire       cmd_wr  = wr & (idx == IDX_CMD);
  wire       opnd_wr = wr & (idx == IDX_OPND);
  wire       resp_rd = rd & (idx == IDX_RESP);
  wire       save_rd = rd & (idx == IDX_SAVE);
  wire       rest_wr = wr & (idx == IDX_RESTORE);
  wire [31:0] cmd_w  = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
  wire [31:0] opnd_w = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
  wire       rest_null = rest_wr & (cmd_w[31:24] == FMT_NULL);
  wire       abort   = save_rd | rest_null;

  // ==========================================================
  // Command sequencer
  // A command is taken only when no earlier operands still wait for hand-off.
  wire       cmd_ok   = cmd_wr & (state_q == SEQ_IDLE);
  wire       cmd_busy = cmd_wr & (state_q != SEQ_IDLE);
  wire [1:0] cmd_cnt  = cmd_w[CMD_CNT_LSB +: 2];
  wire       hand_go  = (state_q == SEQ_HAND) & ~ex_busy & ~abort;
  wire [2:0] cmd_op   = cmd_q[CMD_OP_LSB +: 3];
  wire [RW-1:0] cmd_dst = cmd_q[CMD_DST_LSB +: RW];

  // Next state: operands are collected, then handed to the execution unit.
  always_comb begin
    state_d = state_q;
    case (state_q)
      SEQ_IDLE: begin
        if (cmd_ok) state_d = (cmd_cnt == 2'b00) ? SEQ_HAND : SEQ_OPND;
      end
      SEQ_OPND: begin
        if (opnd_wr && left_q == 2'b01) state_d = SEQ_HAND;
      end
      SEQ_HAND: begin
        if (hand_go) state_d = SEQ_IDLE;
      end
      default: state_d = SEQ_IDLE;
    endcase
    if (abort) state_d = SEQ_IDLE;
  end

  // Sequencer registers.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q    <= SEQ_IDLE;
      cmd_q      <= 8'h00;
      left_q     <= 2'b00;
      opnd_acc_q <= '0;
      wait_q     <= 1'b0;
    end else begin
      state_q <= state_d;
      if (cmd_ok) cmd_q <= cmd_w[7:0];
      if (cmd_ok) left_q <= cmd_cnt;
      else if (opnd_wr && state_q == SEQ_OPND) left_q <= left_q - 2'b01;
      if (opnd_wr) opnd_acc_q <= {opnd_acc_q[FW-33:0], opnd_w};
      if (cmd_busy) wait_q <= 1'b1;
      else if (cmd_ok || abort) wait_q <= 1'b0;
    end
  end

  // ==========================================================
  // Programmer-visible state
  wire trap_set = ex_done & |(ex_exc & ctrl_q[CTRL_EN_LSB +: 8]);

  // Hardware updates land after host writes so a finishing operation is never lost.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q        <= CTRL_RST;
      stat_q        <= STAT_RST;
      iaddr_stage_q <= IADDR_RST;
      iaddr_q       <= IADDR_RST;
      trap_q        <= 1'b0;
      null_q        <= 1'b1;
      ex_dst_q      <= '0;
    end else if (rest_null) begin
      ctrl_q  <= CTRL_RST;
      stat_q  <= STAT_RST;
      iaddr_q <= IADDR_RST;
      trap_q  <= 1'b0;
      null_q  <= 1'b1;
    end else begin
      if (wr && idx == IDX_CTRL) ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i);
      if (wr && idx == IDX_STAT) stat_q <= merge(stat_q, wb_dat_i, wb_sel_i);
      if (wr && idx == IDX_IADDR) iaddr_stage_q <= merge(iaddr_stage_q, wb_dat_i, wb_sel_i);
      if (hand_go) iaddr_q <= iaddr_stage_q;
      if (hand_go) ex_dst_q <= cmd_dst;
      if (cmd_ok) null_q <= 1'b0;
      if (ex_done) begin
        stat_q[STAT_CC_LSB +: 4] <= ex_cc;
        stat_q[STAT_EX_LSB +: 8] <= ex_exc;
        stat_q[STAT_AC_LSB +: 8] <= stat_q[STAT_AC_LSB +: 8] | ex_exc;
      end
      // The trap stays pending until the host reads it; a new one wins over the clear.
      if (trap_set) trap_q <= 1'b1;
      else if (resp_rd) trap_q <= 1'b0;
    end
  end

  // ==========================================================
  // Data path units
  float_data_regs #(
    .NREG (NREG),
    .W    (FW)
  ) u_regs (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr_en   (ex_wr),
    .wr_idx  (ex_dst_q),
    .wr_data (ex_res),
    .rd_idx  (cmd_dst),
    .rd_data (reg_rd)
  );

  arith_execution_unit #(
    .W      (FW),
    .CYCLES (CYCLES)
  ) u_exec (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (hand_go),
    .abort   (abort),
    .op      (cmd_op),
    .opnd    (opnd_acc_q),
    .src     (reg_rd),
    .busy    (ex_busy),
    .done    (ex_done),
    .wr_en   (ex_wr),
    .result  (ex_res),
    .cc      (ex_cc),
    .exc     (ex_exc)
  );

  // ==========================================================
  // Read data
  // Priority: pending trap, then wait, then operand request, then null.
  wire [15:0] resp_w = trap_q ? {RESP_TRAP, 5'h00, TRAP_VEC}
                     : wait_q ? {RESP_WAIT, 13'h0000}
                     : (state_q == SEQ_OPND) ? {RESP_XFER, 11'h000, left_q}
                     : {RESP_NULL, 13'h0000};
  wire [7:0]  fmt_w  = (state_q != SEQ_IDLE || ex_busy) ? FMT_BUSY
                     : null_q ? FMT_NULL : FMT_IDLE;
  wire [31:0] rdata  = (idx == IDX_RESP)  ? {16'h0000, resp_w}
                     : (idx == IDX_CTRL)  ? ctrl_q
                     : (idx == IDX_SAVE)  ? {fmt_w, 24'h00_0000}
                     : (idx == IDX_STAT)  ? stat_q
                     : (idx == IDX_OPND)  ? ex_res[31:0]
                     : (idx == IDX_IADDR) ? iaddr_q
                     : 32'h0000_0000;

  // Bus answer: one-cycle ack; the device never starts a transfer of its own.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_q  <= 1'b0;
      sync_q <= 1'b0;
      dat_q  <= 32'h0000_0000;
    end else begin
      ack_q  <= acc;
      sync_q <= start & sync_rd & ~sync_q;
      dat_q  <= rd ? rdata : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ==========================================================
  // Assertions
  sequence sync_req_s;
    start & sync_rd & ~sync_q;
  endsequence
  sequence sync_ans_s;
    ~wb_ack_o ##1 wb_ack_o;
  endsequence
  sequence exec_run_s;
    ex_busy [*7] ##1 ex_done;
  endsequence

  sync_read_lat_a: assert property (@(posedge sys_clk) disable iff (rst)
    sync_req_s |=> sync_ans_s) else $error("Synchronous read not acked after two cycles.");

  async_lat_a: assert property (@(posedge sys_clk) disable iff (rst)
    start & ~sync_rd |=> wb_ack_o) else $error("Plain access not acked after one cycle.");

  ack_single_a: assert property (@(posedge sys_clk) disable iff (rst)
    wb_ack_o |=> ~wb_ack_o) else $error("Ack held longer than one cycle.");

  no_select_a: assert property (@(posedge sys_clk) disable iff (rst)
    ~hit |=> ~wb_ack_o) else $error("Ack given to an unselected cycle.");

  wait_resp_a: assert property (@(posedge sys_clk) disable iff (rst)
    cmd_busy & ~trap_set & ~trap_q |=> resp_w[15:13] == RESP_WAIT)
    else $error("Refused command did not yield a wait response.");

  trap_resp_a: assert property (@(posedge sys_clk) disable iff (rst)
    trap_set & ~rest_null |=> trap_q ##0 resp_w[15:13] == RESP_TRAP)
    else $error("Enabled exception did not raise a trap response.");

  opnd_req_a: assert property (@(posedge sys_clk) disable iff (rst)
    cmd_ok & (cmd_cnt != 2'b00) & ~abort |=> state_q == SEQ_OPND && left_q == $past(cmd_cnt))
    else $error("Operand request not raised after command.");

  iaddr_cap_a: assert property (@(posedge sys_clk) disable iff (rst)
    hand_go & ~rest_null |=> iaddr_q == $past(iaddr_stage_q))
    else $error("Instruction address not captured at hand-off.");

  save_stop_a: assert property (@(posedge sys_clk) disable iff (rst)
    save_rd |=> state_q == SEQ_IDLE && ~ex_busy) else $error("Save did not stop the device.");

  // A save or a null restore may cut a run short, so either one ends the attempt.
  exec_done_a: assert property (@(posedge sys_clk) disable iff (rst || abort)
    hand_go |=> exec_run_s)
    else $error("Execution latency wrong.");

  rest_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    rest_null |=> ctrl_q == CTRL_RST && stat_q == STAT_RST && ~trap_q && ~ex_busy)
    else $error("Null restore did not return the device to its reset state.");
endmodule : float_coprocessor_host_port

// ---- shared/fpcp_pkg.sv ----
// Shared constants and types for the floating-point coprocessor host port.
package fpcp_pkg;
  // ==========================================================
  // Selection and register map
  localparam logic [2:0] FC_CPU_SPACE = 3'h7;
  localparam int         ID_LSB       = 13;
  localparam int         ID_MSB       = 15;
  localparam int         MAP_LSB      = 5;
  localparam int         MAP_MSB      = 12;
  localparam int         IDX_LSB      = 2;
  localparam int         IDX_MSB      = 4;
  localparam logic [2:0] IDX_RESP     = 3'h0;
  localparam logic [2:0] IDX_CTRL     = 3'h1;
  localparam logic [2:0] IDX_SAVE     = 3'h2;
  localparam logic [2:0] IDX_RESTORE  = 3'h3;
  localparam logic [2:0] IDX_CMD      = 3'h4;
  localparam logic [2:0] IDX_STAT     = 3'h5;
  localparam logic [2:0] IDX_OPND     = 3'h6;
  localparam logic [2:0] IDX_IADDR    = 3'h7;
  // ==========================================================
  // Field layouts and reset values
  localparam int          CTRL_EN_LSB = 8;
  localparam int          STAT_CC_LSB = 24;
  localparam int          STAT_EX_LSB = 8;
  localparam int          STAT_AC_LSB = 0;
  localparam int          CMD_DST_LSB = 0;
  localparam int          CMD_OP_LSB  = 3;
  localparam int          CMD_CNT_LSB = 6;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] STAT_RST    = 32'h0000_0000;
  localparam logic [31:0] IADDR_RST   = 32'h0000_0000;
  localparam logic [7:0]  EXC_DZ      = 8'h04;
  // ==========================================================
  // Operations, responses and save formats
  localparam logic [2:0]  OP_LOAD     = 3'h0;
  localparam logic [2:0]  OP_TEST     = 3'h1;
  localparam logic [2:0]  OP_DIV      = 3'h2;
  localparam logic [2:0]  OP_CLR      = 3'h3;
  localparam logic [2:0]  RESP_NULL   = 3'h0;
  localparam logic [2:0]  RESP_WAIT   = 3'h1;
  localparam logic [2:0]  RESP_XFER   = 3'h2;
  localparam logic [2:0]  RESP_TRAP   = 3'h3;
  localparam logic [7:0]  TRAP_VEC    = 8'h30;
  localparam logic [7:0]  FMT_NULL    = 8'h00;
  localparam logic [7:0]  FMT_IDLE    = 8'h1f;
  localparam logic [7:0]  FMT_BUSY    = 8'h3f;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int EXEC_TIME_NS  = 200;
  localparam int EXEC_CYC      = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_OPND = 2'b01,
    SEQ_HAND = 2'b10
  } seq_state_t;
endpackage : fpcp_pkg

// ---- verilog/float_data_regs.sv ----
// Floating-point data register file with one write and one read port.
`timescale 1ns/10ps
module float_data_regs
  import fpcp_pkg::*;
#(
  parameter int NREG = 8,
  parameter int W    = 80
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic                    wr_en,
  input  wire logic [$clog2(NREG)-1:0] wr_idx,
  input  wire logic [W-1:0]            wr_data,
  input  wire logic [$clog2(NREG)-1:0] rd_idx,
  output      logic [W-1:0]            rd_data
);
  logic [W-1:0] regs_q [NREG];

  // Any register may be written by any instruction except a test.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NREG; i++) regs_q[i] <= '0;
    end else if (wr_en) begin
      regs_q[wr_idx] <= wr_data;
    end
  end

  assign rd_data = regs_q[rd_idx];
endmodule : float_data_regs

// ---- verilog/arith_execution_unit.sv ----
// Execution unit: runs one handed-off operation over a fixed latency.
`timescale 1ns/10ps
module arith_execution_unit
  import fpcp_pkg::*;
#(
  parameter int W      = 80,
  parameter int CYCLES = EXEC_CYC
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic         abort,
  input  wire logic [2:0]   op,
  input  wire logic [W-1:0] opnd,
  input  wire logic [W-1:0] src,
  output      logic         busy,
  output      logic         done,
  output      logic         wr_en,
  output      logic [W-1:0] result,
  output      logic [3:0]   cc,
  output      logic [7:0]   exc
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] CNT_LOAD = CW'(CYCLES);
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);
  logic [CW-1:0] cnt_q;
  logic [2:0]    op_q;
  logic [W-1:0]  opnd_q;
  logic [W-1:0]  src_q;
  wire           last = (cnt_q == CNT_ONE);

  // Abort wins so a context save can stop work mid-operation.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= '0;
      op_q   <= OP_LOAD;
      opnd_q <= '0;
      src_q  <= '0;
    end else if (abort) begin
      cnt_q <= '0;
    end else if (start) begin
      cnt_q  <= CNT_LOAD;
      op_q   <= op;
      opnd_q <= opnd;
      src_q  <= src;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CNT_ONE;
    end
  end

  // Result and flags hold from the cycle after start until the next start.
  assign busy   = (cnt_q != '0);
  assign done   = last & ~abort;
  assign result = (op_q == OP_LOAD) ? opnd_q : (op_q == OP_CLR) ? '0 : src_q;
  assign wr_en  = done & (op_q != OP_TEST);
  assign cc     = {result[W-1], result == '0, 2'b00};
  assign exc    = (op_q == OP_DIV && opnd_q == '0) ? EXC_DZ : 8'h00;
endmodule : arith_execution_unit

// ---- testbench/host_model.sv ----
// Host processor model: issues classic Wishbone cycles with the space code given by the caller.
`timescale 1ns/10ps
module host_model (
  input  wire logic        sys_clk,
  output      logic        wb_cyc_o,
  output      logic        wb_stb_o,
  output      logic        wb_we_o,
  output      logic [15:0] wb_adr_o,
  output      logic [3:0]  wb_sel_o,
  output      logic [31:0] wb_dat_o,
  output      logic [2:0]  fc_o,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i
);
  // ==========================================================
  // Idle bus at time zero.
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 16'h0000;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0000_0000;
    fc_o     = 3'h0;
  end

  // ==========================================================
  // One bus cycle; lat is the count of edges until ack was sampled, 0 when none came.
  // The host moves every word itself, the device never masters the bus.
  task automatic access(input logic we, input logic [2:0] fc, input logic [15:0] adr, input logic [3:0] sel,
                        input logic [31:0] dat, output logic [31:0] rdat, output int lat);
    int n;
    n    = 0;
    lat  = 0;
    rdat = 32'h0000_0000;
    @(posedge sys_clk);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_adr_o <= adr;
    wb_sel_o <= sel;
    wb_dat_o <= dat;
    fc_o     <= fc;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_i !== 1'b1 && n < 64);
    if (wb_ack_i === 1'b1) begin
      lat  = n;
      rdat = wb_dat_i;
    end
    // Released data lines show the inverted word so a stale value never looks valid.
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o  <= 1'b0;
    wb_dat_o <= ~dat;
    @(posedge sys_clk);
  endtask : access
endmodule : host_model

// ---- testbench/float_coprocessor_host_port_tb.sv ----
// Self-checking bench for the coprocessor host port, driven through the host model.
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) begin \
      n_fail++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module float_coprocessor_host_port_tb
  import fpcp_pkg::*;
;
  // ==========================================================
  // Signals, scoreboard queue and counters
  typedef struct packed {
    logic [31:0] e;
    logic [31:0] m;
  } note_t;
  localparam logic [2:0] MY_ID = 3'h5;
  logic        sys_clk;
  logic        rst;
  logic        wb_cyc, wb_stb, wb_we, wb_ack;
  logic [15:0] wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_i, wb_dat_o, rdat, exp_v, d;
  logic [2:0]  fc;
  int          lat;
  int          n_fail      = 0;
  int          checks_done = 0;
  note_t       exp_q[$];
  logic [3:0]  lanes[5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3};

  host_model host (.sys_clk(sys_clk), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we), .wb_adr_o(wb_adr),
                   .wb_sel_o(wb_sel), .wb_dat_o(wb_dat_i), .fc_o(fc), .wb_ack_i(wb_ack), .wb_dat_i(wb_dat_o));
  float_coprocessor_host_port #(.CP_ID(MY_ID), .CYCLES(8)) uut (
    .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_i), .fc_i(fc), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack));

  // ==========================================================
  // Helpers for addresses, command words and response codes
  function automatic logic [15:0] adr_of(input logic [2:0] id, input logic [7:0] map, input logic [2:0] idx);
    return {id, map, idx, 2'b00};
  endfunction : adr_of
  function automatic logic [31:0] cmd(input logic [2:0] op, input logic [1:0] cnt, input logic [2:0] dst);
    return (32'(cnt) << CMD_CNT_LSB) | (32'(op) << CMD_OP_LSB) | (32'(dst) << CMD_DST_LSB);
  endfunction : cmd
  function automatic logic [31:0] resp(input logic [2:0] code, input logic [7:0] low);
    return {16'h0000, code, 5'h00, low};
  endfunction : resp
  task automatic wr(input logic [2:0] idx, input logic [31:0] dv, input logic [3:0] sel = 4'hF,
                    input logic [7:0] map = 8'h00);
    host.access(1'b1, FC_CPU_SPACE, adr_of(MY_ID, map, idx), sel, dv, rdat, lat);
    `CHK(lat, 2)
  endtask : wr
  // Reads note their expectation first; the monitor judges the data when ack shows.
  task automatic rd(input logic [2:0] idx, input logic [31:0] e, input logic [31:0] m,
                    input logic [7:0] map = 8'h00);
    exp_q.push_back('{e: e, m: m});
    host.access(1'b0, FC_CPU_SPACE, adr_of(MY_ID, map, idx), 4'hF, 32'h0000_0000, rdat, lat);
    `CHK(lat, (idx == IDX_RESP || idx == IDX_SAVE) ? 3 : 2)
  endtask : rd
  task automatic close_out;
    `CHK(exp_q.size(), 0)
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // ==========================================================
  // Clock, watchdog and monitor
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    close_out();
  end
  // A read ack with no note waiting means the device answered a cycle it should not have.
  always @(posedge sys_clk) begin
    note_t n;
    if (wb_ack === 1'b1 && wb_we === 1'b0) begin
      if (exp_q.size() == 0) begin
        `CHK(wb_ack, 1'b0)
      end else begin
        n = exp_q.pop_front();
        `CHK(wb_dat_o & n.m, n.e & n.m)
      end
    end else if (wb_ack !== 1'b1 && rst === 1'b0) begin
      `CHK(wb_dat_o, 32'h0000_0000)
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    d   = $urandom(7);
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rd(IDX_CTRL, CTRL_RST, 32'hFFFF_FFFF);
    rd(IDX_STAT, STAT_RST, 32'hFFFF_FFFF);
    rd(IDX_IADDR, IADDR_RST, 32'hFFFF_FFFF);
    rd(IDX_SAVE, {FMT_NULL, 24'h00_0000}, 32'hFF00_0000);
    rd(IDX_RESP, 32'h0000_0000, 32'hFFFF_FFFF);
    // Wrong space code or wrong identifier must go unanswered and change nothing.
    for (int f = 0; f < 7; f++) begin
      host.access(1'b1, 3'(f), adr_of(MY_ID, 8'h00, IDX_CTRL), 4'hF, 32'hFFFF_FFFF, rdat, lat);
      `CHK(lat, 0)
      host.access(1'b1, FC_CPU_SPACE, adr_of(MY_ID ^ 3'(f + 1), 8'h00, IDX_CTRL), 4'hF, 32'hFFFF_FFFF, rdat, lat);
      `CHK(lat, 0)
    end
    rd(IDX_CTRL, CTRL_RST, 32'hFFFF_FFFF);
    // Unmapped places answer, read zero and drop writes.
    wr(IDX_CTRL, 32'hFFFF_FFFF, 4'hF, 8'h80);
    rd(IDX_CTRL, 32'h0000_0000, 32'hFFFF_FFFF, 8'h01);
    rd(IDX_CTRL, CTRL_RST, 32'hFFFF_FFFF);
    // Byte and half-word lanes merge as an 8 or 16 bit host would write them.
    exp_v = $urandom;
    wr(IDX_CTRL, exp_v);
    foreach (lanes[i]) begin
      d = $urandom;
      wr(IDX_CTRL, d, lanes[i]);
      for (int b = 0; b < 4; b++) if (lanes[i][b]) exp_v[8*b +: 8] = d[8*b +: 8];
      rd(IDX_CTRL, exp_v, 32'hFFFF_FFFF);
    end
    wr(IDX_RESTORE, {FMT_NULL, 24'h00_0000});
    rd(IDX_CTRL, CTRL_RST, 32'hFFFF_FFFF);
    d = $urandom;
    wr(IDX_STAT, d);
    rd(IDX_STAT, d, 32'hFFFF_FFFF);
    // Load with two operand words; a second command before hand-off must be told to wait.
    exp_v = $urandom;
    wr(IDX_IADDR, exp_v);
    wr(IDX_CMD, cmd(OP_LOAD, 2'd2, 3'h3));
    rd(IDX_RESP, resp(RESP_XFER, 8'h02), 32'h0000_E003);
    wr(IDX_CMD, cmd(OP_CLR, 2'd0, 3'h0));
    rd(IDX_RESP, resp(RESP_WAIT, 8'h00), 32'h0000_E000);
    wr(IDX_OPND, $urandom);
    d = $urandom;
    wr(IDX_OPND, d);
    repeat (20) @(posedge sys_clk);
    rd(IDX_OPND, d, 32'hFFFF_FFFF);
    rd(IDX_IADDR, exp_v, 32'hFFFF_FFFF);
    rd(IDX_SAVE, {FMT_IDLE, 24'h00_0000}, 32'hFF00_0000);
    // A save while the execution unit runs reports busy and aborts the work.
    wr(IDX_CMD, cmd(OP_CLR, 2'd0, 3'h1));
    rd(IDX_SAVE, {FMT_BUSY, 24'h00_0000}, 32'hFF00_0000);
    rd(IDX_RESP, resp(RESP_NULL, 8'h00), 32'h0000_E000);
    // A test returns the loaded register as its result and writes nothing back.
    wr(IDX_CMD, cmd(OP_TEST, 2'd0, 3'h3));
    repeat (12) @(posedge sys_clk);
    rd(IDX_OPND, d, 32'hFFFF_FFFF);
    // Divide by an all-zero operand with the trap enabled.
    wr(IDX_CTRL, 32'(EXC_DZ) << CTRL_EN_LSB);
    wr(IDX_CMD, cmd(OP_DIV, 2'd3, 3'h2));
    wr(IDX_OPND, 32'h0000_0000);
    rd(IDX_RESP, resp(RESP_XFER, 8'h02), 32'h0000_E003);
    wr(IDX_OPND, 32'h0000_0000);
    wr(IDX_OPND, 32'h0000_0000);
    repeat (20) @(posedge sys_clk);
    rd(IDX_RESP, resp(RESP_TRAP, TRAP_VEC), 32'h0000_E0FF);
    rd(IDX_RESP, resp(RESP_NULL, 8'h00), 32'h0000_E000);
    // The divide source register is still zero, so only the zero flag is set.
    rd(IDX_STAT, {4'h0, 4'h4, 8'h00, EXC_DZ, EXC_DZ}, {4'h0, 4'hF, 8'h00, 8'hFF, EXC_DZ});
    repeat (4) @(posedge sys_clk);
    close_out();
  end
endmodule : float_coprocessor_host_port_tb
